/* File: include/flash_cfg_pkg.sv */
// Notes on behaviour
// - Fast reads insert the dummy count held in volatile_config bits 7 to 4.
// - Dummy count spans one to fifteen; a written zero acts as fifteen.
// - Execute-in-place is enabled only while volatile_config bit 3 is cleared, unless BASIC_XIP is set.
// - Basic execute-in-place builds ignore bit 3 and always allow the mode.
// - Write instructions replace the settings loaded from nonvolatile_config at power-on.
// - Clearing enhanced bit 7 selects the four-line protocol right after the write.
// - Clearing enhanced bit 6 selects two-line unless bit 7 is also cleared.
// - With both protocol bits cleared the four-line protocol wins.
// - Setting bit 7 again returns to extended, or two-line while bit 6 is cleared.
// - Enhanced bit 4 cleared disables the hold/reset function of data_line_three.
// - Power-up restores hold/reset unless the nonvolatile image bit 4 is cleared.
// - Enhanced bit 3 cleared enables program-voltage acceleration for four-line modifies.
// - Accelerated modify in the four-line protocol falls back to extended until the voltage drops or the wait times out.
// - Voltage not raised within 200 ms sets the voltage error flag.
// - Enhanced bits 2 to 0 hold the drive code; 000 and 100 are reserved.
package flash_cfg_pkg;

  // ****************************************************************
  // Instruction codes
  // ****************************************************************
  localparam logic [7:0] OP_WR_CFG = 8'h81;
  localparam logic [7:0] OP_WR_ECFG = 8'h61;
  localparam logic [7:0] OP_CLR_FLAG = 8'h50;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_FOUR_PROG = 8'h32;
  localparam logic [7:0] OP_FOUR_EXT_PROG = 8'h12;
  localparam logic [7:0] OP_SECT_ERASE = 8'hd8;
  localparam logic [7:0] OP_SUB_ERASE = 8'h20;
  localparam logic [7:0] OP_BULK_ERASE = 8'hc7;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CFG_DUMMY_LSB = 4;
  localparam int CFG_XIP_BIT = 3;
  localparam int ECFG_FOUR_BIT = 7;
  localparam int ECFG_TWO_BIT = 6;
  localparam int ECFG_RSVD_BIT = 5;
  localparam int ECFG_HOLD_BIT = 4;
  localparam int ECFG_ACCEL_BIT = 3;
  localparam logic [7:0] CFG_RESET = 8'hf8;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hf8;
  localparam logic [7:0] ECFG_RESET = 8'hdf;
  localparam logic [7:0] ECFG_WRITE_MASK = 8'hdf;
  localparam logic [3:0] DUMMY_ZERO_AS = 4'hf;
  localparam logic [2:0] DRIVE_RSVD_LOW = 3'h0;
  localparam logic [2:0] DRIVE_RSVD_HIGH = 3'h4;
  localparam logic [1:0] IDX_OPCODE = 2'h0;
  localparam logic [1:0] IDX_DATA = 2'h1;
  localparam logic [1:0] IDX_LAST = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int ACCEL_TIMEOUT_MS = 200;
  localparam int ACCEL_TIMEOUT_CYCLES = ACCEL_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    PROTO_EXTENDED = 3'h1,
    PROTO_TWO_LINE = 3'h2,
    PROTO_FOUR_LINE = 3'h4
  } protocol_e;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'h1,
    ACC_WAIT = 3'h2,
    ACC_HIGH = 3'h4
  } accel_e;

  typedef struct packed {
    logic [1:0] idx;
    logic [7:0] data;
  } link_byte_s;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] ecfg;
  } nonvolatile_image_s;

  typedef struct packed {
    protocol_e protocol;
    logic [3:0] dummy_cycles;
    logic xip_enabled;
    logic hold_enabled;
    logic accel_enabled;
    logic [2:0] drive_strength;
    logic fallback_extended;
    logic vpp_flag;
  } config_status_s;

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic [1:0] idx;
    logic [1:0] gray;
    link_byte_s [1:0] slots;
  } link_state_s;

  localparam link_state_s LINK_STATE_RESET = '0;

  // Two-bit gray step: 00, 01, 11, 10.
  function automatic logic [1:0] gray_inc(input logic [1:0] g);
    gray_inc = {g[0], ~g[1]};
  endfunction

endpackage

/* File: rtl/serial_byte_capture.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_byte_capture
  import flash_cfg_pkg::*;
(
  input wire logic sck,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic di,
  output logic [1:0] byte_gray,
  output link_byte_s [1:0] byte_slots
);

  // ****************************************************************
  // Frame tracking on the link clock
  // ****************************************************************
  link_state_s cur_reg;
  link_state_s cur_next;
  logic frame_open_reg;
  logic [7:0] full_byte;

  // The serial clock stops between frames, so the frame is closed by
  // the select line itself rather than by a later clock edge.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      frame_open_reg <= 1'b0;
    end else begin
      frame_open_reg <= 1'b1;
    end
  end

  // Bytes are shifted in most significant bit first. Each finished
  // byte goes to the slot that the next gray count names, so the
  // other slot stays stable for the slow side to read.
  always_comb begin
    cur_next = cur_reg;
    full_byte = {cur_reg.shift, di};
    cur_next.shift = full_byte[6:0];
    if (!frame_open_reg) begin
      cur_next.bit_cnt = 3'h1;
      cur_next.idx = IDX_OPCODE;
    end else if (cur_reg.bit_cnt == 3'h7) begin
      cur_next.bit_cnt = 3'h0;
      cur_next.gray = gray_inc(cur_reg.gray);
      cur_next.slots[cur_next.gray[1] ^ cur_next.gray[0]] = '{idx: cur_reg.idx, data: full_byte};
      if (cur_reg.idx != IDX_LAST) begin
        cur_next.idx = cur_reg.idx + 2'h1;
      end
    end else begin
      cur_next.bit_cnt = cur_reg.bit_cnt + 3'h1;
    end
  end

  // The system reset is applied without this clock, which may be idle.
  always_ff @(posedge sck or posedge sys_rst) begin
    if (sys_rst) begin
      cur_reg <= LINK_STATE_RESET;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign byte_gray = cur_reg.gray;
  assign byte_slots = cur_reg.slots;

endmodule
`default_nettype wire

/* File: rtl/serial_flash_volatile_config.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_flash_volatile_config
  import flash_cfg_pkg::*;
#(
  parameter int unsigned ACCEL_TIMEOUT = ACCEL_TIMEOUT_CYCLES,
  parameter bit BASIC_XIP = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic di,
  input wire logic vpp_high,
  input wire nonvolatile_image_s nv_image,
  output logic [7:0] volatile_config,
  output logic [7:0] volatile_enhanced_config,
  output config_status_s status
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam logic [23:0] TIMER_LAST = 24'(ACCEL_TIMEOUT - 1);

  typedef struct packed {
    logic [1:0] gray_s1;
    logic [1:0] gray_s2;
    logic [1:0] gray_seen;
    logic cs_s1;
    logic cs_s2;
    logic vpp_s1;
    logic vpp_s2;
    logic loaded;
    logic frame_active;
    logic [7:0] opcode;
    logic [7:0] data;
    logic have_data;
    logic [7:0] cfg;
    logic [7:0] ecfg;
    accel_e acc;
    logic [23:0] timer;
    logic fallback;
    logic vpp_flag;
    config_status_s out;
  } cfg_state_s;

  localparam cfg_state_s STATE_RESET = '{
    gray_s1: 2'h0, gray_s2: 2'h0, gray_seen: 2'h0,
    cs_s1: 1'b1, cs_s2: 1'b1, vpp_s1: 1'b0, vpp_s2: 1'b0,
    loaded: 1'b0, frame_active: 1'b0, opcode: 8'h00, data: 8'h00,
    have_data: 1'b0, cfg: CFG_RESET, ecfg: ECFG_RESET, acc: ACC_IDLE,
    timer: 24'h000000, fallback: 1'b0, vpp_flag: 1'b0,
    out: '{protocol: PROTO_EXTENDED, dummy_cycles: DUMMY_ZERO_AS,
           xip_enabled: BASIC_XIP, hold_enabled: 1'b1, accel_enabled: 1'b0,
           drive_strength: 3'h7, fallback_extended: 1'b0, vpp_flag: 1'b0}
  };

  cfg_state_s r_reg;
  cfg_state_s r_next;
  logic [1:0] byte_gray;
  link_byte_s [1:0] byte_slots;
  logic new_byte;
  logic frame_end;
  logic is_modify;
  logic is_four_instr;
  logic flag_set;
  logic flag_clr;
  link_byte_s got;

  // ****************************************************************
  // Link side capture
  // ****************************************************************
  serial_byte_capture serial_byte_capture_inst (
    .sck(sck),
    .sys_rst(sys_rst),
    .cs_n(cs_n),
    .di(di),
    .byte_gray(byte_gray),
    .byte_slots(byte_slots)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic protocol_e decode_protocol(input logic [7:0] e);
    if (!e[ECFG_FOUR_BIT]) begin
      decode_protocol = PROTO_FOUR_LINE;
    end else if (!e[ECFG_TWO_BIT]) begin
      decode_protocol = PROTO_TWO_LINE;
    end else begin
      decode_protocol = PROTO_EXTENDED;
    end
  endfunction

  // A frame is finished once select is high and every byte it carried
  // has been taken; this covers select rising before the last byte.
  always_comb begin
    new_byte = (r_reg.gray_s2 != r_reg.gray_seen);
    frame_end = r_reg.cs_s2 && r_reg.frame_active && !new_byte;
    is_four_instr = (r_reg.opcode == OP_FOUR_PROG) || (r_reg.opcode == OP_FOUR_EXT_PROG);
    is_modify = is_four_instr || (r_reg.opcode == OP_PAGE_PROG) ||
                (r_reg.opcode == OP_SECT_ERASE) || (r_reg.opcode == OP_SUB_ERASE) ||
                (r_reg.opcode == OP_BULK_ERASE);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_next = r_reg;
    flag_set = 1'b0;
    flag_clr = 1'b0;
    got = byte_slots[r_next.gray_seen[0]];
    // The first stage of each synchroniser feeds only the second.
    r_next.gray_s1 = byte_gray;
    r_next.gray_s2 = r_reg.gray_s1;
    r_next.cs_s1 = cs_n;
    r_next.cs_s2 = r_reg.cs_s1;
    r_next.vpp_s1 = vpp_high;
    r_next.vpp_s2 = r_reg.vpp_s1;

    // Power-on load from the nonvolatile image, one cycle after release.
    if (!r_reg.loaded) begin
      r_next.loaded = 1'b1;
      r_next.cfg = nv_image.cfg & CFG_WRITE_MASK;
      r_next.ecfg = nv_image.ecfg & ECFG_WRITE_MASK;
    end

    // Bytes are spaced eight link clocks apart, so one step per cycle
    // always keeps up and the slot read is never being rewritten.
    if (new_byte) begin
      r_next.gray_seen = gray_inc(r_reg.gray_seen);
      got = byte_slots[r_next.gray_seen[1] ^ r_next.gray_seen[0]];
      r_next.frame_active = 1'b1;
      if (got.idx == IDX_OPCODE) begin
        r_next.opcode = got.data;
        r_next.have_data = 1'b0;
      end else if (got.idx == IDX_DATA) begin
        r_next.data = got.data;
        r_next.have_data = 1'b1;
      end
    end

    // Writes take effect at deselect, replacing whatever was loaded.
    if (frame_end) begin
      r_next.frame_active = 1'b0;
      if (r_reg.opcode == OP_WR_CFG && r_reg.have_data) begin
        r_next.cfg = r_reg.data & CFG_WRITE_MASK;
      end else if (r_reg.opcode == OP_WR_ECFG && r_reg.have_data) begin
        r_next.ecfg = r_reg.data & ECFG_WRITE_MASK;
        // A reserved drive code is refused and the old code kept.
        if (r_reg.data[2:0] == DRIVE_RSVD_LOW || r_reg.data[2:0] == DRIVE_RSVD_HIGH) begin
          r_next.ecfg[2:0] = r_reg.ecfg[2:0];
        end
      end else if (r_reg.opcode == OP_CLR_FLAG) begin
        flag_clr = 1'b1;
      end else if (is_modify && !r_reg.ecfg[ECFG_ACCEL_BIT] && r_reg.acc == ACC_IDLE &&
                   (is_four_instr || decode_protocol(r_reg.ecfg) == PROTO_FOUR_LINE)) begin
        r_next.acc = ACC_WAIT;
        r_next.timer = 24'h000000;
        r_next.fallback = (decode_protocol(r_reg.ecfg) == PROTO_FOUR_LINE);
      end
    end

    // Acceleration: wait for the high voltage, then for it to fall.
    unique case (r_reg.acc)
      ACC_IDLE: begin
      end
      ACC_WAIT: begin
        if (r_reg.vpp_s2) begin
          r_next.acc = ACC_HIGH;
        end else if (r_reg.timer == TIMER_LAST) begin
          r_next.acc = ACC_IDLE;
          r_next.fallback = 1'b0;
          flag_set = 1'b1;
        end else begin
          r_next.timer = r_reg.timer + 24'h000001;
        end
      end
      ACC_HIGH: begin
        if (!r_reg.vpp_s2) begin
          r_next.acc = ACC_IDLE;
          r_next.fallback = 1'b0;
        end
      end
      default: begin
        r_next.acc = ACC_IDLE;
      end
    endcase

    // A timeout in the same cycle as a clear still leaves the flag set.
    r_next.vpp_flag = flag_set | (r_reg.vpp_flag & ~flag_clr);

    // Outputs are built from the next values so they leave a flop.
    r_next.out.protocol = r_next.fallback ? PROTO_EXTENDED : decode_protocol(r_next.ecfg);
    r_next.out.dummy_cycles = (r_next.cfg[7:CFG_DUMMY_LSB] == 4'h0) ? DUMMY_ZERO_AS :
                              r_next.cfg[7:CFG_DUMMY_LSB];
    r_next.out.xip_enabled = BASIC_XIP | ~r_next.cfg[CFG_XIP_BIT];
    r_next.out.hold_enabled = r_next.ecfg[ECFG_HOLD_BIT];
    r_next.out.accel_enabled = ~r_next.ecfg[ECFG_ACCEL_BIT];
    r_next.out.drive_strength = r_next.ecfg[2:0];
    r_next.out.fallback_extended = r_next.fallback;
    r_next.out.vpp_flag = r_next.vpp_flag;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_reg <= STATE_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign volatile_config = r_reg.cfg;
  assign volatile_enhanced_config = r_reg.ecfg;
  assign status = r_reg.out;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence cfg_write_seq;
    frame_end && r_reg.opcode == OP_WR_CFG && r_reg.have_data;
  endsequence

  sequence accel_start_seq;
    frame_end && is_modify && !r_reg.ecfg[ECFG_ACCEL_BIT] && r_reg.acc == ACC_IDLE &&
    decode_protocol(r_reg.ecfg) == PROTO_FOUR_LINE;
  endsequence

  dummy_track_a: assert property (
    r_reg.loaded && (r_reg.cfg[7:4] != 4'h0) |-> status.dummy_cycles == r_reg.cfg[7:4])
    else $error("dummy count does not follow the configuration field");

  dummy_range_a: assert property (
    r_reg.loaded |-> status.dummy_cycles != 4'h0)
    else $error("dummy count reached zero");

  xip_gate_a: assert property (
    (!BASIC_XIP && r_reg.cfg[CFG_XIP_BIT]) |-> !status.xip_enabled)
    else $error("execute in place enabled while its bit is set");

  basic_xip_a: assert property (
    BASIC_XIP |-> status.xip_enabled)
    else $error("basic build refused execute in place");

  cfg_write_a: assert property (
    cfg_write_seq |=> r_reg.cfg == ($past(r_reg.data) & CFG_WRITE_MASK))
    else $error("configuration write not applied at deselect");

  four_line_a: assert property (
    (!r_reg.fallback && !r_reg.ecfg[ECFG_FOUR_BIT]) |-> status.protocol == PROTO_FOUR_LINE)
    else $error("four line protocol not selected");

  two_line_a: assert property (
    (!r_reg.fallback && r_reg.ecfg[ECFG_FOUR_BIT] && !r_reg.ecfg[ECFG_TWO_BIT])
    |-> status.protocol == PROTO_TWO_LINE)
    else $error("two line protocol not selected");

  reserved_bit_a: assert property (
    r_reg.loaded |-> !r_reg.ecfg[ECFG_RSVD_BIT])
    else $error("reserved enhanced bit reads as one");

  drive_code_a: assert property (
    r_reg.loaded |-> status.drive_strength != DRIVE_RSVD_LOW &&
    status.drive_strength != DRIVE_RSVD_HIGH)
    else $error("drive strength holds a reserved code");

  accel_off_a: assert property (
    (r_reg.acc == ACC_IDLE && r_reg.ecfg[ECFG_ACCEL_BIT]) |=> r_reg.acc == ACC_IDLE)
    else $error("acceleration started while disabled");

  fallback_a: assert property (
    accel_start_seq |=> status.protocol == PROTO_EXTENDED ##1
    (status.protocol == PROTO_EXTENDED || r_reg.acc == ACC_IDLE))
    else $error("no extended fallback after accelerated modify");

  timeout_a: assert property (
    (r_reg.acc == ACC_WAIT && r_reg.timer == TIMER_LAST && !r_reg.vpp_s2)
    |=> r_reg.vpp_flag && r_reg.acc == ACC_IDLE && !status.fallback_extended)
    else $error("voltage timeout did not raise the flag");

  hold_pin_a: assert property (
    $changed(r_reg.ecfg[ECFG_HOLD_BIT]) |=> status.hold_enabled == $past(r_reg.ecfg[4]))
    else $error("hold enable does not follow its bit");

  ext_proto_a: assert property (
    (!r_reg.fallback && r_reg.ecfg[ECFG_FOUR_BIT] && r_reg.ecfg[ECFG_TWO_BIT])
    |-> status.protocol == PROTO_EXTENDED)
    else $error("extended protocol not restored");

  flag_sticky_a: assert property (
    (r_reg.vpp_flag && !(frame_end && r_reg.opcode == OP_CLR_FLAG)) |=> r_reg.vpp_flag)
    else $error("voltage flag dropped without a clear");

  flag_clear_a: assert property (
    (frame_end && r_reg.opcode == OP_CLR_FLAG && !flag_set) |=> !r_reg.vpp_flag)
    else $error("voltage flag not cleared");

endmodule
`default_nettype wire

/* File: tb/spi_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  output var logic sck,
  output var logic cs_n,
  output var logic di
);

  // The host idles deselected with the serial clock parked low.
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    di = 1'b0;
  end

  // One frame: opcode then optional data, MSB first, data moved while sck is low.
  // No reads are issued, so no dummy-cycle reads depend on the clock rate.
  task automatic send(input logic [7:0] op, input logic [7:0] dat, input int nbytes);
    logic [15:0] sh;
    int i;
    sh = {op, dat};
    #3.3;
    cs_n = 1'b0;
    for (i = 0; i < 8 * nbytes; i++) begin
      di = sh[15 - i];
      #7.5;
      sck = 1'b1;
      #7.5;
      sck = 1'b0;
    end
    #7.5;
    cs_n = 1'b1;
    // A released data line must not look like it still holds the last bit.
    di = ~di;
    #100;
  endtask

endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import flash_cfg_pkg::*;

  // ****************************************************************
  // Stimulus, clock and design
  // ****************************************************************
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic vpp_high = 1'b0;
  nonvolatile_image_s nv_image = '{cfg: 8'h5f, ecfg: 8'hef};
  wire sck;
  wire cs_n;
  wire di;
  logic [7:0] vcfg;
  logic [7:0] vecfg;
  config_status_s status;
  config_status_s status_basic;
  int error_cnt = 0;
  int checks_done = 0;

  // System clock at 50 MHz.
  always #10 clk = ~clk;

  // Short accelerator timeout keeps the voltage scenarios brief.
  serial_flash_volatile_config #(.ACCEL_TIMEOUT(200), .BASIC_XIP(1'b0))
    serial_flash_volatile_config_inst (.clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n),
    .di(di), .vpp_high(vpp_high), .nv_image(nv_image), .volatile_config(vcfg),
    .volatile_enhanced_config(vecfg), .status(status));

  // Basic variant shares every input so its enable can be compared directly.
  if (1) begin : basic_variant
    serial_flash_volatile_config #(.ACCEL_TIMEOUT(200), .BASIC_XIP(1'b1))
      serial_flash_volatile_config_inst (.clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n),
      .di(di), .vpp_high(vpp_high), .nv_image(nv_image), .volatile_config(),
      .volatile_enhanced_config(), .status(status_basic));
  end

  spi_host_model spi_host_model_inst (.sck(sck), .cs_n(cs_n), .di(di));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Registers settle at most six cycles after deselect, so eight is enough.
  task automatic frame(input logic [7:0] op, input logic [7:0] dat, input int nbytes);
    spi_host_model_inst.send(op, dat, nbytes);
    cycles(8);
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic reset_and_load();
    cycles(4);
    chk("cfg in reset", 16'(vcfg), 16'h00f8);
    chk("ecfg in reset", 16'(vecfg), 16'h00df);
    chk("drive in reset", 16'(status.drive_strength), 16'h0007);
    sys_rst = 1'b0;
    cycles(3);
    chk("cfg loaded", 16'(vcfg), 16'h0058);
    chk("ecfg loaded", 16'(vecfg), 16'h00cf);
    chk("hold from image", 16'(status.hold_enabled), 16'h0000);
    chk("dummy loaded", 16'(status.dummy_cycles), 16'h0005);
  endtask

  task automatic config_writes();
    frame(OP_WR_CFG, 8'h07, 2);
    chk("cfg low bits", 16'(vcfg), 16'h0000);
    chk("zero dummy", 16'(status.dummy_cycles), 16'h000f);
    chk("xip on", 16'(status.xip_enabled), 16'h0001);
    frame(OP_WR_CFG, 8'h18, 2);
    chk("dummy one", 16'(status.dummy_cycles), 16'h0001);
    chk("xip off", 16'(status.xip_enabled), 16'h0000);
    chk("basic xip", 16'(status_basic.xip_enabled), 16'h0001);
    frame(OP_WR_CFG, 8'ha0, 1);
    chk("no data byte", 16'(vcfg), 16'h0018);
  endtask

  task automatic protocol_table();
    logic [7:0] wr [6];
    protocol_e ep [6];
    int i;
    wr = '{8'hff, 8'h9f, 8'h5f, 8'h1f, 8'h9f, 8'hdf};
    ep = '{PROTO_EXTENDED, PROTO_TWO_LINE, PROTO_FOUR_LINE, PROTO_FOUR_LINE,
           PROTO_TWO_LINE, PROTO_EXTENDED};
    for (i = 0; i < 6; i++) begin
      frame(OP_WR_ECFG, wr[i], 2);
      chk("protocol", 16'(status.protocol), 16'(ep[i]));
      chk("ecfg bit5", 16'(vecfg), 16'(wr[i] & 8'hdf));
    end
  endtask

  task automatic hold_and_drive();
    frame(OP_WR_ECFG, 8'hcf, 2);
    chk("hold off", 16'(status.hold_enabled), 16'h0000);
    frame(OP_WR_ECFG, 8'hd8, 2);
    chk("drive 000 kept", 16'(vecfg), 16'h00df);
    chk("hold on", 16'(status.hold_enabled), 16'h0001);
    frame(OP_WR_ECFG, 8'hdc, 2);
    chk("drive 100 kept", 16'(vecfg), 16'h00df);
    frame(OP_WR_ECFG, 8'hdd, 2);
    chk("drive 101", 16'(status.drive_strength), 16'h0005);
  endtask

  task automatic accel_voltage();
    frame(OP_WR_ECFG, 8'h57, 2);
    chk("accel on", 16'(status.accel_enabled), 16'h0001);
    frame(OP_PAGE_PROG, 8'h3c, 2);
    chk("fallback", 16'(status.fallback_extended), 16'h0001);
    chk("ext during fallback", 16'(status.protocol), 16'(PROTO_EXTENDED));
    // The host raises the voltage well inside the allowed window.
    vpp_high = 1'b1;
    cycles(10);
    chk("fallback while high", 16'(status.fallback_extended), 16'h0001);
    vpp_high = 1'b0;
    cycles(10);
    chk("fallback ends", 16'(status.fallback_extended), 16'h0000);
    chk("four again", 16'(status.protocol), 16'(PROTO_FOUR_LINE));
    chk("no flag", 16'(status.vpp_flag), 16'h0000);
    frame(OP_FOUR_PROG, 8'h55, 2);
    cycles(142);
    chk("flag early", 16'(status.vpp_flag), 16'h0000);
    cycles(80);
    chk("flag late", 16'(status.vpp_flag), 16'h0001);
    chk("fallback timeout", 16'(status.fallback_extended), 16'h0000);
    frame(OP_CLR_FLAG, 8'h00, 1);
    chk("flag cleared", 16'(status.vpp_flag), 16'h0000);
    frame(OP_WR_ECFG, 8'h5f, 2);
    frame(OP_FOUR_PROG, 8'haa, 2);
    chk("no fallback", 16'(status.fallback_extended), 16'h0000);
    cycles(250);
    chk("no flag disabled", 16'(status.vpp_flag), 16'h0000);
  endtask

  // Four-line erases and extended-protocol four-input programs take the other accelerator paths; an extended-protocol erase takes none.
  task automatic accel_paths();
    logic [7:0] er [2];
    int i;
    er = '{OP_SECT_ERASE, OP_BULK_ERASE};
    frame(OP_WR_ECFG, 8'hd7, 2);
    frame(OP_SUB_ERASE, 8'h00, 1);
    cycles(230);
    chk("ext erase no timer", 16'(status.vpp_flag), 16'h0000);
    frame(OP_FOUR_EXT_PROG, 8'h11, 2);
    chk("ext no fallback", 16'(status.fallback_extended), 16'h0000);
    chk("ext protocol kept", 16'(status.protocol), 16'(PROTO_EXTENDED));
    cycles(230);
    chk("ext timeout flag", 16'(status.vpp_flag), 16'h0001);
    frame(OP_CLR_FLAG, 8'h00, 1);
    chk("ext flag cleared", 16'(status.vpp_flag), 16'h0000);
    frame(OP_WR_ECFG, 8'h57, 2);
    for (i = 0; i < 2; i++) begin
      frame(er[i], 8'h00, 1);
      chk("erase fallback", 16'(status.fallback_extended), 16'h0001);
      vpp_high = 1'b1;
      cycles(10);
      vpp_high = 1'b0;
      cycles(10);
      chk("erase fallback ends", 16'(status.fallback_extended), 16'h0000);
      chk("erase no flag", 16'(status.vpp_flag), 16'h0000);
    end
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    reset_and_load();
    config_writes();
    protocol_table();
    hold_and_drive();
    accel_voltage();
    accel_paths();
    complete_run();
  end

  // A hang is cut short and reported as a mismatch.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("mismatch at %0t: run did not finish", $time);
    complete_run();
  end

endmodule
`default_nettype wire
